// ===== logic/tc_out_chan.sv
/*
   One compare output channel: the internal output latch, its update on a
   compare match or forced compare, and the port pin override.
   Assumes match and force_cmp are one-cycle pulses on the same clock.
*/
`timescale 1ns/100ps
module tc_out_chan import tc_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [1:0] action,
   input wire logic match,
   input wire logic force_cmp,
   input wire logic port_data,
   input wire logic port_dir,
   output logic latch,
   output logic pin_out,
   output logic pin_oe
);

   // Latch is cleared by reset or a clear action, never by a pin level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch <= 1'b0;
      end else if (match || force_cmp) begin
         unique case (action)
            ACT_NONE: latch <= latch;
            ACT_TOGGLE: latch <= ~latch;
            ACT_CLEAR: latch <= 1'b0;
            ACT_SET: latch <= 1'b1;
         endcase
      end
   end

   // Override replaces data only; direction stays with the port
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= (action != ACT_NONE) ? latch : port_data;
         pin_oe <= port_dir;
      end
   end

endmodule

// ===== logic/tc_pkg.sv
/*
   Shared constants and carrier types for the 16-bit timer with compare
   outputs: register offsets, field codes, reset values and prescaler masks.
   Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package tc_pkg;

   // ==========================================================
   // Register offsets (byte addresses, low 8 address bits)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ACTION = 8'h04;
   localparam logic [7:0] OFF_PORT_DATA = 8'h08;
   localparam logic [7:0] OFF_PORT_DIR = 8'h0c;
   localparam logic [7:0] OFF_FORCE = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   localparam logic [7:0] OFF_CAPTURE = 8'h18;
   localparam logic [7:0] OFF_FLAGS = 8'h1c;
   localparam logic [7:0] OFF_LATCH = 8'h20;
   localparam logic [7:0] OFF_CMP_BASE = 8'h40;
   localparam logic [7:0] WORD_STEP = 8'h04;

   // ==========================================================
   // Waveform mode select codes
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
   localparam logic [3:0] MODE_CTC_CAPT = 4'hc;

   // Compare output action codes (non-PWM modes)
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // Clock select codes: 0 stops the timer
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;

   localparam int PRESC_W = 10;
   localparam logic [PRESC_W-1:0] MASK_DIV1 = 10'h000;
   localparam logic [PRESC_W-1:0] MASK_DIV8 = 10'h007;
   localparam logic [PRESC_W-1:0] MASK_DIV64 = 10'h03f;
   localparam logic [PRESC_W-1:0] MASK_DIV256 = 10'h0ff;
   localparam logic [PRESC_W-1:0] MASK_DIV1024 = 10'h3ff;

   // ==========================================================
   // Counter values, flag positions, reset values
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CAPT = 1;
   localparam int FLAG_CMP0 = 2;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] RST_CMP = 16'h0000;
   localparam logic [15:0] RST_CAPTURE = 16'h0000;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic [2:0] clk_sel;
      logic [3:0] mode;
   } tc_ctrl_t;

   localparam tc_ctrl_t RST_CTRL = '{clk_sel: CS_STOP, mode: MODE_NORMAL};

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } tc_addr_phase_t;

endpackage

// ===== logic/tc_prescaler.sv
/*
   Prescaler: free-running divider producing a one-cycle timer tick enable
   at hclk divided by 1, 8, 64, 256 or 1024, or none when stopped.
   Assumes clk_sel comes from logic on the same clock.
*/
`timescale 1ns/100ps
module tc_prescaler import tc_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] clk_sel,
   output logic tick
);

   logic [PRESC_W-1:0] div_cnt;
   logic [PRESC_W-1:0] mask;

   always_comb begin
      unique case (clk_sel)
         CS_DIV1: mask = MASK_DIV1;
         CS_DIV8: mask = MASK_DIV8;
         CS_DIV64: mask = MASK_DIV64;
         CS_DIV256: mask = MASK_DIV256;
         default: mask = MASK_DIV1024;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // Codes 6 and 7 also stop the timer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick <= 1'b0;
      end else begin
         tick <= (clk_sel != CS_STOP) && (clk_sel <= CS_DIV1024)
            && ((div_cnt & mask) == mask);
      end
   end

endmodule

// ===== logic/tc_timer.sv
/*
   16-bit timer/counter with compare outputs, normal and clear-on-match
   counting, prescaler and an AHB-Lite register slave.
   Assumes a single AHB-Lite master, word transfers only, and interrupt
   acknowledge pulses from logic on hclk.
*/
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

// What this block does
// - Reset clears every compare output latch to low.
// - Action field picks the latch value applied at the next match.
// - Nonzero action drives latch onto pin; direction stays with port.
// - Latch can be preset while the port direction keeps the pin released.
// - Action fields never touch the capture logic.
// - Action zero leaves the latch unchanged on a match.
// - New action value first used by the latch at the next match or force after the write.
// - Force strobe applies the action at once in non-PWM modes.
// - Counting depends on mode select only, not on action fields.
// - Non-PWM action sets, clears or toggles; no PWM modes are built.
// - Normal mode counts up, never clears, wraps max to zero.
// - Normal mode sets overflow flag as count becomes zero; only sets.
// - Overflow flag clears when its interrupt is taken.
// - Normal mode accepts counter writes at any time.
// - Clear-on-match resets at top: compare A (mode 4) or capture (12).
// - Reaching top raises compare A or capture flag as applicable.
// - Top writes apply directly; below count means run through wrap.
// - Action 1 toggles channel A latch on each match.
// - Toggle output runs at clock over 2*N*(1+top).
// - Prescaler divides by 1, 8, 64, 256 or 1024.
// - Clear-on-match sets overflow flag when count passes max to zero.
// - Compare flag sets one timer tick after count equals compare.
// - A counter write blocks all matches in the next timer tick.
// - Forced compare only updates the latch; no flag, no counter change.
module tc_timer import tc_pkg::*; #(
   parameter int NUM_CH = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic ovf_irq_ack,
   input wire logic capt_irq_ack,
   input wire logic [NUM_CH-1:0] cmp_irq_ack,
   output logic [NUM_CH-1:0] pin_out,
   output logic [NUM_CH-1:0] pin_oe,
   output logic [NUM_CH+1:0] flags
);

   localparam int FLAG_W = NUM_CH + 2;

   // ==========================================================
   // Register state
   tc_ctrl_t ctrl;
   logic [2*NUM_CH-1:0] action;
   logic [NUM_CH-1:0] port_data;
   logic [NUM_CH-1:0] port_dir;
   logic [15:0] count;
   logic [15:0] capture_value;
   logic [15:0] cmp [NUM_CH];
   logic [NUM_CH-1:0] latch;
   tc_addr_phase_t ap;

   // ==========================================================
   // Timer internals
   logic tick;
   logic block;
   logic ctc_mode;
   logic non_pwm;
   logic [15:0] top_value;
   logic at_top;
   logic [NUM_CH-1:0] match;
   logic [NUM_CH-1:0] match_pend;
   logic capt_pend;
   logic [NUM_CH-1:0] force_cmp;
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;
   logic [31:0] next_rdata;

   // ==========================================================
   // Bus write decode (data phase)
   logic wr;
   logic wr_ctrl;
   logic wr_action;
   logic wr_pdata;
   logic wr_pdir;
   logic wr_force;
   logic wr_count;
   logic wr_capture;
   logic wr_flags;
   logic accept;

   assign wr = ap.valid && ap.write;
   assign wr_ctrl = wr && (ap.addr == OFF_CTRL);
   assign wr_action = wr && (ap.addr == OFF_ACTION);
   assign wr_pdata = wr && (ap.addr == OFF_PORT_DATA);
   assign wr_pdir = wr && (ap.addr == OFF_PORT_DIR);
   assign wr_force = wr && (ap.addr == OFF_FORCE);
   assign wr_count = wr && (ap.addr == OFF_COUNT);
   assign wr_capture = wr && (ap.addr == OFF_CAPTURE);
   assign wr_flags = wr && (ap.addr == OFF_FLAGS);
   assign accept = hsel && hready && htrans[1];

   // ==========================================================
   // AHB-Lite slave: zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap <= '0;
      end else if (hready) begin
         ap.valid <= accept;
         ap.write <= hwrite;
         ap.addr <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data sampled at the address phase, stands through the data phase
   // Limitation: a read right behind a write to it returns the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (accept && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // Unmapped addresses and the force register read as zero
   always_comb begin
      next_rdata = '0;
      unique case (haddr[7:0])
         OFF_CTRL: next_rdata[6:0] = ctrl;
         OFF_ACTION: next_rdata[2*NUM_CH-1:0] = action;
         OFF_PORT_DATA: next_rdata[NUM_CH-1:0] = port_data;
         OFF_PORT_DIR: next_rdata[NUM_CH-1:0] = port_dir;
         OFF_COUNT: next_rdata[15:0] = count;
         OFF_CAPTURE: next_rdata[15:0] = capture_value;
         OFF_FLAGS: next_rdata[FLAG_W-1:0] = flags;
         OFF_LATCH: next_rdata[NUM_CH-1:0] = latch;
         default: begin
            for (int i = 0; i < NUM_CH; i++) begin
               if (haddr[7:0] == OFF_CMP_BASE + 8'(i * WORD_STEP)) begin
                  next_rdata[15:0] = cmp[i];
               end
            end
         end
      endcase
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl <= hwdata[6:0];
      end
   end

   // Latch takes it at the next match or force; override at once; no retroactive update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         action <= '0;
      end else if (wr_action) begin
         action <= hwdata[2*NUM_CH-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_data <= '0;
         port_dir <= '0;
      end else begin
         if (wr_pdata) begin
            port_data <= hwdata[NUM_CH-1:0];
         end
         if (wr_pdir) begin
            port_dir <= hwdata[NUM_CH-1:0];
         end
      end
   end

   // Top registers unbuffered: a value below count waits for the wrap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture_value <= RST_CAPTURE;
      end else if (wr_capture) begin
         capture_value <= hwdata[15:0];
      end
   end

   // ==========================================================
   // Prescaler
   tc_prescaler u_presc (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_sel(ctrl.clk_sel),
      .tick(tick)
   );

   // ==========================================================
   // Counting: mode select alone shapes the sequence
   assign ctc_mode = (ctrl.mode == MODE_CTC_CMPA) || (ctrl.mode == MODE_CTC_CAPT);
   // PWM is left out: other codes count as normal but refuse force
   assign non_pwm = ctc_mode || (ctrl.mode == MODE_NORMAL);
   assign top_value = (ctrl.mode == MODE_CTC_CAPT) ? capture_value : cmp[0];
   assign at_top = tick && ctc_mode && !block && (count == top_value);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= RST_COUNT;
      end else if (wr_count) begin
         count <= hwdata[15:0];
      end else if (at_top) begin
         count <= COUNT_BOTTOM;
      end else if (tick) begin
         count <= count + 1'b1;
      end
   end

   // Write blocks matches until the following tick has passed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         block <= 1'b0;
      end else if (wr_count) begin
         block <= 1'b1;
      end else if (tick) begin
         block <= 1'b0;
      end
   end

   // ==========================================================
   // Compare channels
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gen_ch
         assign match[g] = tick && !block && (count == cmp[g]);
         assign force_cmp[g] = wr_force && hwdata[g] && non_pwm;

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cmp[g] <= RST_CMP;
            end else if (wr && (ap.addr == OFF_CMP_BASE + 8'(g * WORD_STEP))) begin
               cmp[g] <= hwdata[15:0];
            end
         end

         // Flag follows the match by one timer tick
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               match_pend[g] <= 1'b0;
            end else if (tick) begin
               match_pend[g] <= match[g];
            end
         end

         assign flag_set[FLAG_CMP0 + g] = tick && match_pend[g];
         assign flag_clr[FLAG_CMP0 + g] = cmp_irq_ack[g]
            || (wr_flags && hwdata[FLAG_CMP0 + g]);

         tc_out_chan u_chan (
            .hclk(hclk),
            .hresetn(hresetn),
            .action(action[2*g +: 2]),
            .match(match[g]),
            .force_cmp(force_cmp[g]),
            .port_data(port_data[g]),
            .port_dir(port_dir[g]),
            .latch(latch[g]),
            .pin_out(pin_out[g]),
            .pin_oe(pin_oe[g])
         );
      end
   endgenerate

   // ==========================================================
   // Flags: set beats clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capt_pend <= 1'b0;
      end else if (tick) begin
         capt_pend <= at_top && (ctrl.mode == MODE_CTC_CAPT);
      end
   end

   // Count passes max to zero whether by wrap or by a top of max
   assign flag_set[FLAG_OVF] = tick && !wr_count && (count == COUNT_MAX);
   assign flag_set[FLAG_CAPT] = tick && capt_pend;
   assign flag_clr[FLAG_OVF] = ovf_irq_ack || (wr_flags && hwdata[FLAG_OVF]);
   assign flag_clr[FLAG_CAPT] = capt_irq_ack || (wr_flags && hwdata[FLAG_CAPT]);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= '0;
      end else begin
         flags <= flag_set | (flags & ~flag_clr);
      end
   end

endmodule

// ===== verification/tc_pin_load.sv
/*
   Load on the compare output pins: resolves each pin's level.
   Assumes a pull-down on every pin.
*/
`timescale 1ns/100ps
module tc_pin_load #(
   parameter int NUM_CH = 2
) (
   input wire logic [NUM_CH-1:0] pin_out,
   input wire logic [NUM_CH-1:0] pin_oe,
   output logic [NUM_CH-1:0] level
);
   // Released pin falls to the pull-down, never keeps its last value
   assign level = pin_out & pin_oe;
endmodule

// ===== verification/tc_timer_sva.sv
/*
   Checker for tc_timer: bus answer, flag clearing, pin enables, reset.
   Sees only the timer's ports; bound to every tc_timer instance.
*/
`timescale 1ns/100ps
module tc_timer_sva import tc_pkg::*; #(
   parameter int NUM_CH = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic ovf_irq_ack,
   input wire logic capt_irq_ack,
   input wire logic [NUM_CH-1:0] cmp_irq_ack,
   input wire logic [NUM_CH-1:0] pin_out,
   input wire logic [NUM_CH-1:0] pin_oe,
   input wire logic [NUM_CH+1:0] flags
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================================
   // Helpers: data phase of a write, shadow of clock select
   logic wr_dp;
   logic [7:0] wr_a;
   logic [2:0] cs_sh;
   logic [2:0] stop_cnt;
   logic wr_flg;
   logic wr_dir;
   assign wr_flg = wr_dp && wr_a == OFF_FLAGS;
   assign wr_dir = wr_dp && wr_a == OFF_PORT_DIR;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dp <= 1'b0;
         wr_a <= 8'h00;
      end else begin
         wr_dp <= hsel && hready && htrans[1] && hwrite;
         wr_a <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs_sh <= CS_STOP;
      end else if (wr_dp && wr_a == OFF_CTRL) begin
         cs_sh <= hwdata[6:4];
      end
   end
   // Margin of four cycles lets a tick already in flight land
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_cnt <= 3'h0;
      end else if (cs_sh != CS_STOP && cs_sh <= CS_DIV1024) begin
         stop_cnt <= 3'h0;
      end else if (stop_cnt != 3'h4) begin
         stop_cnt <= stop_cnt + 3'h1;
      end
   end
   // ==========================================================
   // Properties
   property p_reset_low;
      $rose(hresetn) |-> pin_out == '0 && flags == '0;
   endproperty
   a_reset_low: assert property (p_reset_low) else $error("pins or flags set after reset");
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus stalled or errored");
   property p_oe_dir;
      $changed(pin_oe) |-> $past(wr_dir) || $past(wr_dir, 2);
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("pin enable moved alone");
   property p_stop_quiet;
      stop_cnt == 3'h4 |-> !$rose(flags[FLAG_OVF]) && !$rose(flags[FLAG_CMP0]);
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("flag rose while stopped");
   property p_ovf_clr;
      $fell(flags[FLAG_OVF]) |-> $past(ovf_irq_ack) || ($past(wr_flg) && $past(hwdata[0]));
   endproperty
   a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag fell");
   property p_capt_clr;
      $fell(flags[FLAG_CAPT]) |-> $past(capt_irq_ack) || ($past(wr_flg) && $past(hwdata[1]));
   endproperty
   a_capt_clr: assert property (p_capt_clr) else $error("capture flag fell");
   property p_cmp0_clr;
      $fell(flags[2]) |-> $past(cmp_irq_ack[0]) || ($past(wr_flg) && $past(hwdata[2]));
   endproperty
   a_cmp0_clr: assert property (p_cmp0_clr) else $error("compare flag 0 fell");
   property p_cmp1_clr;
      $fell(flags[3]) |-> $past(cmp_irq_ack[1]) || ($past(wr_flg) && $past(hwdata[3]));
   endproperty
   a_cmp1_clr: assert property (p_cmp1_clr) else $error("compare flag 1 fell");
endmodule

bind tc_timer tc_timer_sva #(.NUM_CH(NUM_CH)) u_sva (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .ovf_irq_ack(ovf_irq_ack),
   .capt_irq_ack(capt_irq_ack), .cmp_irq_ack(cmp_irq_ack), .pin_out(pin_out),
   .pin_oe(pin_oe), .flags(flags));

// ===== verification/tc_timer_test.sv
/*
   Self-checking bench for tc_timer: register rows, forced compares,
   clear-on-match periods, overflow, match blocking.
   Assumes tc_pkg, tc_timer, tc_pin_load and the bound checker.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tc_timer_test import tc_pkg::*; ;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tc_row_t;
   typedef struct {logic [3:0] m; logic [2:0] cs; logic [15:0] top; int per;} tc_ctc_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic ovf_irq_ack = 1'b0;
   logic capt_irq_ack = 1'b0;
   logic [1:0] cmp_irq_ack = 2'b00;
   wire hreadyout;
   wire hresp;
   wire [31:0] hrdata;
   wire [1:0] pin_out;
   wire [1:0] pin_oe;
   wire [1:0] level;
   wire [3:0] flags;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   logic [31:0] rv;
   tc_row_t rows[10];
   tc_ctc_t clear_on_match_mode[5];
   logic [1:0] codes[4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE};
   logic exp_l[4] = '{1'b1, 1'b0, 1'b1, 1'b1};

   always #12.5 hclk = ~hclk;

   tc_timer #(.NUM_CH(2)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .ovf_irq_ack(ovf_irq_ack), .capt_irq_ack(capt_irq_ack), .cmp_irq_ack(cmp_irq_ack),
      .pin_out(pin_out), .pin_oe(pin_oe), .flags(flags));
   tc_pin_load #(.NUM_CH(2)) u_load (.pin_out(pin_out), .pin_oe(pin_oe), .level(level));

   // ==========================================================
   // Bus tasks: entered just after a rising edge
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task rd(input logic [7:0] a);
      xfer(a, 1'b0, 32'h0);
   endtask
   // Cycles until the next rising edge of channel 0's pin
   task rise();
      logic p;
      p = level[0];
      @(negedge hclk);
      n++;
      while (!(level[0] === 1'b1 && p === 1'b0)) begin
         p = level[0];
         @(negedge hclk);
         n++;
      end
      @(posedge hclk);
   endtask
   task finish_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         $display("timeout at %0t", $time);
         finish_test();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      rows = '{'{OFF_LATCH, 32'hffffffff, 32'h0}, '{OFF_FLAGS, 32'hffffffff, 32'h0},
         '{OFF_CMP_BASE, 32'hffff1234, 32'h1234}, '{OFF_CAPTURE, 32'habcd, 32'habcd},
         '{OFF_CMP_BASE + WORD_STEP, 32'hbeef, 32'hbeef}, '{OFF_COUNT, 32'hf0042, 32'h42},
         '{OFF_PORT_DATA, 32'hff, 32'h3}, '{OFF_ACTION, 32'hff, 32'hf},
         '{OFF_FORCE, 32'h0, 32'h0}, '{8'h3c, 32'hffffffff, 32'h0}};
      clear_on_match_mode = '{'{MODE_CTC_CMPA, CS_DIV1, 16'h0, 2}, '{MODE_CTC_CMPA, CS_DIV8, 16'h3, 64},
         '{MODE_CTC_CAPT, CS_DIV64, 16'h1, 256}, '{MODE_CTC_CMPA, CS_DIV256, 16'h0, 512},
         '{MODE_CTC_CAPT, CS_DIV1024, 16'h0, 2048}};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         `CHK(rv, rows[i].e)
      end
      `CHK(level, 2'b00)
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         wr(OFF_ACTION, {30'h0, codes[i]});
         wr(OFF_FORCE, 32'h1);
         rd(OFF_LATCH);
         `CHK(rv[1:0], {1'b0, exp_l[i]})
      end
      rd(OFF_FLAGS);
      `CHK(rv[3:0], 4'h0)
      wr(OFF_PORT_DATA, 32'h0);
      wr(OFF_PORT_DIR, 32'h3);
      repeat (3) @(posedge hclk);
      `CHK(level, 2'b00)
      wr(OFF_ACTION, 32'h1);
      repeat (3) @(posedge hclk);
      `CHK(level, 2'b01)
      wr(OFF_PORT_DIR, 32'h0);
      repeat (3) @(posedge hclk);
      `CHK(level, 2'b00)
      wr(OFF_PORT_DIR, 32'h1);
      $display("test force done");
      foreach (clear_on_match_mode[i]) begin
         wr(OFF_CTRL, {25'h0, CS_STOP, clear_on_match_mode[i].m});
         wr(OFF_CMP_BASE, {16'h0, clear_on_match_mode[i].m == MODE_CTC_CAPT ? 16'h0 : clear_on_match_mode[i].top});
         wr(OFF_CAPTURE, {16'h0, clear_on_match_mode[i].top});
         // Blocked first tick wraps max to zero, so the overflow flag is set
         wr(OFF_COUNT, {16'h0, COUNT_MAX});
         wr(OFF_FLAGS, 32'hf);
         wr(OFF_CTRL, {25'h0, clear_on_match_mode[i].cs, clear_on_match_mode[i].m});
         rise();
         n = 0;
         rise();
         `CHK(n, clear_on_match_mode[i].per)
         wr(OFF_CTRL, {25'h0, CS_STOP, clear_on_match_mode[i].m});
         rd(OFF_FLAGS);
         `CHK(rv[clear_on_match_mode[i].m == MODE_CTC_CAPT ? FLAG_CAPT : FLAG_CMP0], 1'b1)
         `CHK(rv[FLAG_OVF], 1'b1)
      end
      $display("test clear on match done");
      wr(OFF_CTRL, {25'h0, CS_STOP, MODE_NORMAL});
      wr(OFF_ACTION, 32'h2);
      wr(OFF_FORCE, 32'h1);
      wr(OFF_ACTION, 32'h3);
      wr(OFF_CMP_BASE, 32'h10);
      wr(OFF_COUNT, 32'h10);
      wr(OFF_CTRL, {25'h0, CS_DIV1, MODE_NORMAL});
      repeat (4) @(posedge hclk);
      rd(OFF_LATCH);
      `CHK(rv[0], 1'b0)
      wr(OFF_CTRL, {25'h0, CS_STOP, MODE_NORMAL});
      wr(OFF_CMP_BASE, 32'h2);
      wr(OFF_CMP_BASE + WORD_STEP, 32'hfffe);
      wr(OFF_COUNT, 32'hfffc);
      wr(OFF_FLAGS, 32'hf);
      wr(OFF_CTRL, {25'h0, CS_DIV1, MODE_NORMAL});
      repeat (10) @(posedge hclk);
      wr(OFF_CTRL, {25'h0, CS_STOP, MODE_NORMAL});
      rd(OFF_COUNT);
      `CHK(rv[15:0] > 16'h2 && rv[15:0] < 16'h10, 1'b1)
      rd(OFF_FLAGS);
      `CHK(rv[0], 1'b1)
      `CHK(flags[FLAG_OVF], 1'b1)
      ovf_irq_ack <= 1'b1;
      capt_irq_ack <= 1'b1;
      cmp_irq_ack <= 2'b11;
      @(posedge hclk);
      ovf_irq_ack <= 1'b0;
      capt_irq_ack <= 1'b0;
      cmp_irq_ack <= 2'b00;
      rd(OFF_FLAGS);
      `CHK(rv[3:0], 4'h0)
      `CHK(flags, 4'h0)
      $display("test overflow done");
      finish_test();
   end
endmodule
